// file: hw/bot_pkg.sv
// Constants, types and the block check for the telegram framer
package bot_pkg;
	// Start code identification field and flag bits
	localparam logic [3:0] BOT_ID_READ = 4'ha;
	localparam logic [3:0] BOT_ID_WRITE = 4'hc;
	localparam int BOT_SC_ADDR_BIT = 0;
	localparam int BOT_SC_FWD_BIT = 1;
	localparam int BOT_SC_ONE_BIT = 2;
	localparam int BOT_SC_FMT_BIT = 3;
	// Answer start codes and fixed answer length field
	localparam logic [7:0] BOT_SC_RSP = 8'h05;
	localparam logic [7:0] BOT_SC_ACK = 8'h06;
	localparam logic [7:0] BOT_SC_NAK = 8'h07;
	localparam logic [7:0] BOT_ACK_LEN = 8'h01;
	// Largest answer length field: 253 data bytes
	localparam logic [7:0] BOT_RSP_MAX_LEN = 8'hfc;
	// Object address group: index high, index low, subindex
	localparam logic [8:0] BOT_GROUP_BYTES = 9'h003;
	localparam logic [15:0] BOT_CRC_POLY = 16'h1021;
	localparam logic [15:0] BOT_CRC_INIT = 16'h0000;
	// Receive gap limit
	localparam int BOT_GAP_US = 5000;
	localparam int BOT_CLK_KHZ = 10000;
	localparam int BOT_GAP_CYCLES = BOT_GAP_US * BOT_CLK_KHZ / 1000;
	// Buffer entry: first flag, last flag, data byte
	localparam int BOT_BUF_W = 10;

	typedef enum logic [1:0] {
		BOT_ANS_RSP,
		BOT_ANS_ACK,
		BOT_ANS_NAK
	} bot_ans_t;

	////////////////////////////////////////////////////////////////
	// Table entry of the upper byte, xor shifted crc, xor byte
	function automatic logic [15:0] bot_crc_next(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] t;
		t = {crc[15:8], 8'h00};
		for (int i = 0; i < 8; i++) begin
			t = t[15] ? ({t[14:0], 1'b0} ^ BOT_CRC_POLY) : {t[14:0], 1'b0};
		end
		return t ^ {crc[7:0], 8'h00} ^ {8'h00, b};
	endfunction : bot_crc_next
endpackage : bot_pkg

// file: hw/bot_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module bot_buf
	import bot_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [BOT_BUF_W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [BOT_BUF_W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][BOT_BUF_W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} bot_buf_state_t;

	bot_buf_state_t s;
	bot_buf_state_t next_s;
	logic push;
	logic pop;

	assign in_ready = s.cnt != 2'd2;
	assign out_valid = s.cnt != 2'd0;
	assign out_data = s.mem[s.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = ~s.wp;
		end
		if (pop) begin
			next_s.rp = ~s.rp;
		end
		next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : bot_buf

// file: hw/bot_framer.sv
// Binary object telegram framer: request parser and answer builder
`timescale 1ns/1ns
module bot_framer
	import bot_pkg::*;
#(
	parameter int GAP_CYCLES = BOT_GAP_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Configuration
	input wire logic multidrop,
	input wire logic [7:0] node_addr,
	// Received byte stream
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [7:0] rx_data,
	// Text bytes handed to the command line path
	output logic text_valid,
	output logic [7:0] text_data,
	// Request payload stream
	output logic req_valid,
	input wire logic req_ready,
	output logic [7:0] req_data,
	output logic req_first,
	output logic req_last,
	output logic req_is_write,
	output logic value_format_select,
	// Request end status
	output logic frame_done,
	output logic frame_crc_err,
	output logic frame_len_err,
	output logic frame_timeout,
	// Answer request
	input wire logic ans_start,
	input wire bot_ans_t ans_type,
	input wire logic [7:0] ans_len,
	input wire logic [15:0] ans_err,
	output logic ans_busy,
	// Answer value bytes
	input wire logic ans_valid,
	output logic ans_ready,
	input wire logic [7:0] ans_data,
	// Transmitted byte stream
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data
);
	typedef enum logic [2:0] {
		BOT_RX_IDLE,
		BOT_RX_ADDR,
		BOT_RX_LEN,
		BOT_RX_DATA,
		BOT_RX_CRCH,
		BOT_RX_CRCL
	} bot_rx_t;

	typedef enum logic [2:0] {
		BOT_TX_IDLE,
		BOT_TX_SC,
		BOT_TX_LEN,
		BOT_TX_DATA,
		BOT_TX_CRCH,
		BOT_TX_CRCL
	} bot_tx_t;

	typedef struct packed {
		bot_rx_t rx_st;
		logic [15:0] rx_crc;
		logic [7:0] rx_crc_hi;
		logic [7:0] rx_len;
		logic [8:0] rx_idx;
		logic discard;
		logic is_write;
		logic fmt;
		logic [31:0] gap;
		logic text_valid;
		logic [7:0] text_data;
		logic done;
		logic crc_err;
		logic len_err;
		logic timeout;
		bot_tx_t tx_st;
		bot_ans_t tx_type;
		logic [7:0] tx_len;
		logic [7:0] tx_cnt;
		logic [15:0] tx_err;
		logic [15:0] tx_crc;
		logic tx_valid;
		logic [7:0] tx_data;
	} bot_state_t;

	bot_state_t s;
	bot_state_t next_s;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [BOT_BUF_W-1:0] buf_in_data;
	logic [BOT_BUF_W-1:0] buf_out_data;
	logic rx_take;
	logic sc_ok;
	logic tx_free;
	logic ans_take;
	logic [7:0] ans_byte;
	logic [8:0] pay_cnt;

	////////////////////////////////////////////////////////////////
	// Payload buffer

	bot_buf u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(req_valid),
		.out_ready(req_ready),
		.out_data(buf_out_data)
	);

	////////////////////////////////////////////////////////////////
	// Handshakes

	// Stalled only while a kept payload byte cannot enter the buffer
	assign rx_ready = (s.rx_st != BOT_RX_DATA) || s.discard || buf_in_ready;
	assign rx_take = rx_valid && rx_ready;
	assign buf_in_valid = rx_valid && (s.rx_st == BOT_RX_DATA) && !s.discard;
	// First and last flags travel with each payload byte
	assign buf_in_data = {s.rx_idx == 9'h000, s.rx_idx == {1'b0, s.rx_len}, rx_data};
	assign pay_cnt = {1'b0, s.rx_len} + 9'h001;

	// Request start: read or write id, bit 2 set, forwarding clear
	assign sc_ok = ((rx_data[7:4] == BOT_ID_READ) || (rx_data[7:4] == BOT_ID_WRITE))
		&& rx_data[BOT_SC_ONE_BIT]
		&& !rx_data[BOT_SC_FWD_BIT];

	// Output register may load when empty or being emptied
	assign tx_free = !s.tx_valid || tx_ready;
	assign ans_ready = tx_free && (s.tx_st == BOT_TX_DATA) && (s.tx_type == BOT_ANS_RSP);
	assign ans_take = ans_ready && ans_valid;
	assign ans_busy = s.tx_st != BOT_TX_IDLE;

	// Data byte source per answer type
	always_comb begin
		unique case (s.tx_type)
			BOT_ANS_RSP: ans_byte = ans_data;
			BOT_ANS_ACK: ans_byte = 8'h00;
			default: ans_byte = (s.tx_cnt == 8'h00) ? s.tx_err[15:8] : s.tx_err[7:0];
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.text_valid = 1'b0;
		next_s.done = 1'b0;
		next_s.timeout = 1'b0;
		// Receive side
		// Byte gap watch runs from the start code on
		if (s.rx_st != BOT_RX_IDLE) begin
			if (rx_take) begin
				next_s.gap = '0;
			end else if (s.gap >= GAP_CYCLES - 1) begin
				next_s.rx_st = BOT_RX_IDLE;
				next_s.timeout = 1'b1;
				next_s.gap = '0;
			end else begin
				next_s.gap = s.gap + 32'd1;
			end
		end
		if (rx_take) begin
			// Check bytes stay out of the running crc
			if (s.rx_st != BOT_RX_CRCH && s.rx_st != BOT_RX_CRCL) begin
				next_s.rx_crc = bot_crc_next(s.rx_crc, rx_data);
			end
			unique case (s.rx_st)
				BOT_RX_IDLE: begin
					if (sc_ok) begin
						next_s.rx_crc = bot_crc_next(BOT_CRC_INIT, rx_data);
						next_s.is_write = rx_data[7:4] == BOT_ID_WRITE;
						next_s.fmt = rx_data[BOT_SC_FMT_BIT];
						next_s.discard = 1'b0;
						next_s.gap = '0;
						next_s.rx_st = rx_data[BOT_SC_ADDR_BIT] ? BOT_RX_ADDR : BOT_RX_LEN;
					end else begin
						// Anything else belongs to the text command path
						next_s.text_valid = 1'b1;
						next_s.text_data = rx_data;
					end
				end
				BOT_RX_ADDR: begin
					next_s.discard = multidrop && (rx_data != node_addr);
					next_s.rx_st = BOT_RX_LEN;
				end
				BOT_RX_LEN: begin
					next_s.rx_len = rx_data;
					next_s.rx_idx = '0;
					next_s.rx_st = BOT_RX_DATA;
				end
				BOT_RX_DATA: begin
					next_s.rx_idx = s.rx_idx + 9'h001;
					// Last byte when the index reaches the length field
					if (s.rx_idx == {1'b0, s.rx_len}) begin
						next_s.rx_st = BOT_RX_CRCH;
					end
				end
				BOT_RX_CRCH: begin
					next_s.rx_crc_hi = rx_data;
					next_s.rx_st = BOT_RX_CRCL;
				end
				BOT_RX_CRCL: begin
					next_s.rx_st = BOT_RX_IDLE;
					next_s.done = !s.discard;
					// Another node's frame leaves the last status alone
					if (!s.discard) begin
						next_s.crc_err = {s.rx_crc_hi, rx_data} != s.rx_crc;
						next_s.len_err = s.is_write ? (pay_cnt < BOT_GROUP_BYTES)
							: ((pay_cnt % BOT_GROUP_BYTES) != 9'h000);
					end
				end
				default: next_s.rx_st = BOT_RX_IDLE;
			endcase
		end
		// Transmit side
		// Byte handed on frees the output register
		if (s.tx_valid && tx_ready) begin
			next_s.tx_valid = 1'b0;
		end
		unique case (s.tx_st)
			BOT_TX_IDLE: begin
				if (ans_start) begin
					next_s.tx_type = ans_type;
					next_s.tx_err = ans_err;
					// Length field is the data byte count minus one
					next_s.tx_len = BOT_ACK_LEN;
					if (ans_type == BOT_ANS_RSP) begin
						next_s.tx_len = (ans_len > BOT_RSP_MAX_LEN) ? BOT_RSP_MAX_LEN : ans_len;
					end
					next_s.tx_st = BOT_TX_SC;
				end
			end
			BOT_TX_SC: begin
				if (tx_free) begin
					unique case (s.tx_type)
						BOT_ANS_RSP: next_s.tx_data = BOT_SC_RSP;
						BOT_ANS_ACK: next_s.tx_data = BOT_SC_ACK;
						default: next_s.tx_data = BOT_SC_NAK;
					endcase
					// Crc restarts from zero with every answer
					next_s.tx_crc = bot_crc_next(BOT_CRC_INIT, next_s.tx_data);
					next_s.tx_valid = 1'b1;
					next_s.tx_st = BOT_TX_LEN;
				end
			end
			BOT_TX_LEN: begin
				if (tx_free) begin
					next_s.tx_data = s.tx_len;
					next_s.tx_crc = bot_crc_next(s.tx_crc, s.tx_len);
					next_s.tx_valid = 1'b1;
					next_s.tx_cnt = '0;
					next_s.tx_st = BOT_TX_DATA;
				end
			end
			BOT_TX_DATA: begin
				if ((s.tx_type == BOT_ANS_RSP) ? ans_take : tx_free) begin
					next_s.tx_data = ans_byte;
					next_s.tx_crc = bot_crc_next(s.tx_crc, ans_byte);
					next_s.tx_valid = 1'b1;
					next_s.tx_cnt = s.tx_cnt + 8'h01;
					if (s.tx_cnt == s.tx_len) begin
						next_s.tx_st = BOT_TX_CRCH;
					end
				end
			end
			BOT_TX_CRCH: begin
				if (tx_free) begin
					next_s.tx_data = s.tx_crc[15:8];
					next_s.tx_valid = 1'b1;
					next_s.tx_st = BOT_TX_CRCL;
				end
			end
			BOT_TX_CRCL: begin
				if (tx_free) begin
					next_s.tx_data = s.tx_crc[7:0];
					next_s.tx_valid = 1'b1;
					next_s.tx_st = BOT_TX_IDLE;
				end
			end
			default: next_s.tx_st = BOT_TX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs

	assign req_first = buf_out_data[9];
	assign req_last = buf_out_data[8];
	assign req_data = buf_out_data[7:0];
	assign req_is_write = s.is_write;
	assign value_format_select = s.fmt;
	assign text_valid = s.text_valid;
	assign text_data = s.text_data;
	// Error levels hold until the next kept frame ends; done and timeout are one-cycle pulses
	assign frame_done = s.done;
	assign frame_crc_err = s.crc_err;
	assign frame_len_err = s.len_err;
	assign frame_timeout = s.timeout;
	assign tx_valid = s.tx_valid;
	assign tx_data = s.tx_data;
endmodule : bot_framer

// file: verification/bot_framer_properties.sv
// Port checks for the telegram framer
`timescale 1ns/1ns
module bot_framer_properties
	import bot_pkg::*;
#(
	parameter int GAP_CYCLES = BOT_GAP_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Byte streams
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic [7:0] rx_data,
	input wire logic text_valid,
	input wire logic [7:0] text_data,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [7:0] req_data,
	input wire logic frame_timeout,
	// Answer side
	input wire logic ans_start,
	input wire bot_ans_t ans_type,
	input wire logic ans_busy,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	int gap;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) gap <= 0;
		else gap <= (rx_valid && rx_ready) ? 0 : gap + 1;
	end
	property p_ack_code;
		ans_start && !ans_busy && ans_type == BOT_ANS_ACK |-> ##[1:2] tx_valid && tx_data == 8'h06;
	endproperty
	a_ack_code: assert property (p_ack_code) else $error("ack start code wrong");
	property p_nak_code;
		ans_start && !ans_busy && ans_type == BOT_ANS_NAK |-> ##[1:2] tx_valid && tx_data == 8'h07;
	endproperty
	a_nak_code: assert property (p_nak_code) else $error("nak start code wrong");
	property p_rsp_code;
		ans_start && !ans_busy && ans_type == BOT_ANS_RSP |-> ##[1:2] tx_valid && tx_data == 8'h05;
	endproperty
	a_rsp_code: assert property (p_rsp_code) else $error("data start code wrong");
	property p_text_cause;
		text_valid |-> $past(rx_valid && rx_ready) && text_data == $past(rx_data);
	endproperty
	a_text_cause: assert property (p_text_cause) else $error("text byte without cause");
	property p_text_kind;
		text_valid |-> !(text_data[7:4] inside {4'ha, 4'hc} && text_data[2] && !text_data[1]);
	endproperty
	a_text_kind: assert property (p_text_kind) else $error("start code sent as text");
	property p_timeout_gap;
		frame_timeout |-> gap >= GAP_CYCLES - 2 && gap <= GAP_CYCLES + 2;
	endproperty
	a_timeout_gap: assert property (p_timeout_gap) else $error("timeout at wrong gap");
	property p_rx_stall;
		!rx_ready |-> req_valid;
	endproperty
	a_rx_stall: assert property (p_rx_stall) else $error("refused byte with room");
	property p_req_hold;
		req_valid && !req_ready |=> req_valid && $stable(req_data);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("payload byte lost");
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("answer byte lost");
	c_timeout: cover property (frame_timeout);
	c_stall: cover property (rx_valid && !rx_ready);
	c_ack: cover property (ans_start && ans_type == BOT_ANS_ACK);
endmodule : bot_framer_properties
////////////////////////////////////////////////////////////////
bind bot_framer bot_framer_properties #(.GAP_CYCLES(GAP_CYCLES)) u_bot_framer_properties (
	.sys_clk(sys_clk), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
	.text_valid(text_valid), .text_data(text_data), .req_valid(req_valid),
	.req_ready(req_ready), .req_data(req_data), .frame_timeout(frame_timeout),
	.ans_start(ans_start), .ans_type(ans_type), .ans_busy(ans_busy), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_data(tx_data)
);

// file: verification/bot_host.sv
// Controller model: sends request bytes, takes answer bytes
`timescale 1ns/1ns
module bot_host (
	// Clock
	input wire logic sys_clk,
	// Toward the framer
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data,
	// From the framer
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data
);
	logic slow = 1'b0;
	int bad = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	task automatic put(input logic [7:0] b);
		int i;
		@(negedge sys_clk);
		rx_valid = 1'b1;
		rx_data = b;
		for (i = 0; i < 400 && !rx_ready; i++) @(negedge sys_clk);
		if (!rx_ready) bad++;
		@(posedge sys_clk);
	endtask : put
	// Released line shows the inverse
	task automatic idle();
		@(negedge sys_clk);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask : idle
	task automatic get(output logic [7:0] b);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge sys_clk);
			tx_ready = !slow || i[0];
			if (tx_ready && tx_valid) break;
		end
		if (i == 400) bad++;
		b = tx_data;
		@(posedge sys_clk);
	endtask : get
endmodule : bot_host

// file: verification/tb_binary_object_telegram_framer.sv
// Self-checking bench for the telegram framer
`timescale 1ns/1ns
module tb_binary_object_telegram_framer;
	import bot_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, multidrop = 1'b1, req_ready = 1'b1, ans_start = 1'b0;
	logic ans_valid = 1'b0, stalled = 1'b0, err_seen = 1'b0, rx_valid, rx_ready, text_valid;
	logic req_valid, req_first, req_last, req_is_write, value_format_select, frame_done;
	logic frame_crc_err, frame_len_err, frame_timeout, ans_busy, ans_ready, tx_valid, tx_ready;
	logic [7:0] node_addr = 8'h03, ans_len = 8'h00, ans_data = 8'h00;
	logic [7:0] rx_data, text_data, req_data, tx_data;
	logic [15:0] ans_err = 16'h0000;
	bot_ans_t ans_type = BOT_ANS_ACK;
	logic [7:0] req_q[$], text_q[$], val_q[$];
	logic [1:0] mark_q[$];
	logic len_seen = 1'b0;
	int error_cnt = 0, n_tests = 0, done_cnt = 0;
	always #50 sys_clk = ~sys_clk;
	bot_framer #(.GAP_CYCLES(200)) u_bot_framer (
		.sys_clk(sys_clk), .rst(rst), .multidrop(multidrop), .node_addr(node_addr),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .text_valid(text_valid),
		.text_data(text_data), .req_valid(req_valid), .req_ready(req_ready), .req_data(req_data),
		.req_first(req_first), .req_last(req_last), .req_is_write(req_is_write),
		.value_format_select(value_format_select), .frame_done(frame_done),
		.frame_crc_err(frame_crc_err), .frame_len_err(frame_len_err),
		.frame_timeout(frame_timeout), .ans_start(ans_start), .ans_type(ans_type),
		.ans_len(ans_len), .ans_err(ans_err), .ans_busy(ans_busy), .ans_valid(ans_valid),
		.ans_ready(ans_ready), .ans_data(ans_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data)
	);
	bot_host u_bot_host (
		.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data)
	);
	always @(posedge sys_clk) begin
		if (req_valid && req_ready) req_q.push_back(req_data);
		if (req_valid && req_ready) mark_q.push_back({req_first, req_last});
		if (text_valid) text_q.push_back(text_data);
		if (frame_done) done_cnt++;
		if (frame_done) err_seen = frame_crc_err;
		if (frame_done) len_seen = frame_len_err;
		if (rx_valid && !rx_ready) stalled = 1'b1;
		if (ans_valid && ans_ready) void'(val_q.pop_front());
		if (u_bot_host.bad != 0) complete_run();
	end
	always @(negedge sys_clk) begin
		ans_valid <= val_q.size() != 0;
		ans_data <= val_q.size() != 0 ? val_q[0] : 8'h00;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
		logic [15:0] t;
		t = {c[15:8], 8'h00};
		for (int i = 0; i < 8; i++) t = t[15] ? {t[14:0], 1'b0} ^ 16'h1021 : {t[14:0], 1'b0};
		return t ^ {c[7:0], 8'h00} ^ {8'h00, b};
	endfunction : crc_step
	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic send(input logic [7:0] t[$], input logic [7:0] flip, output logic [15:0] c);
		c = 16'h0000;
		foreach (t[i]) begin
			c = crc_step(c, t[i]);
			u_bot_host.put(t[i]);
		end
		u_bot_host.put(c[15:8]);
		u_bot_host.put(c[7:0] ^ flip);
		u_bot_host.idle();
		repeat (3) @(negedge sys_clk);
	endtask : send
	task automatic answer(input bot_ans_t k, input logic [7:0] e[$]);
		logic [7:0] b;
		logic [15:0] c;
		c = 16'h0000;
		@(negedge sys_clk);
		ans_type = k;
		ans_start = 1'b1;
		@(negedge sys_clk);
		ans_start = 1'b0;
		check(24'(ans_busy), 24'h1);
		foreach (e[i]) c = crc_step(c, e[i]);
		e.push_back(c[15:8]);
		e.push_back(c[7:0]);
		foreach (e[i]) begin
			u_bot_host.get(b);
			check(24'(b), 24'(e[i]));
		end
		@(negedge sys_clk);
		check(24'({ans_busy, tx_valid}), 24'h0);
		$display("answer done");
	endtask : answer
	task automatic t_text();
		logic [7:0] v[$] = '{8'h4f, 8'ha6, 8'h05, 8'ha0};
		check(24'({tx_valid, req_valid, rx_ready, ans_busy, ans_ready, text_valid, frame_done,
			frame_timeout}), 24'h20);
		foreach (v[i]) u_bot_host.put(v[i]);
		u_bot_host.idle();
		repeat (3) @(negedge sys_clk);
		check(24'(text_q.size()), 24'h4);
		foreach (v[i]) check(24'(text_q[i]), 24'(v[i]));
		$display("text done");
	endtask : t_text
	task automatic t_read();
		logic [15:0] c;
		send('{8'ha5, 8'h03, 8'h02, 8'h02, 8'ha8, 8'h05}, 8'h00, c);
		check(24'(c), 24'he146);
		check(24'(len_seen), 24'h0);
		check({err_seen, req_is_write, value_format_select, 21'(done_cnt)}, 24'h1);
		check({req_q[0], req_q[1], req_q[2]}, 24'h02a805);
		check({18'h0, mark_q[0], mark_q[1], mark_q[2]}, 24'h21);
		$display("read done");
	endtask : t_read
	task automatic t_write();
		logic [15:0] c;
		node_addr = 8'h02;
		req_ready = 1'b0;
		req_q = {};
		mark_q = {};
		fork
			send('{8'hc5, 8'h02, 8'h08, 8'h07, 8'h6d, 8'h01, 8'h00, 8'h09, 8'h2e, 8'h00,
				8'h00, 8'h00}, 8'h00, c);
			begin
				repeat (30) @(negedge sys_clk);
				req_ready = 1'b1;
			end
		join
		check(24'(c), 24'h95d5);
		check({stalled, req_is_write, 22'(req_q.size())}, 24'hc00009);
		check({req_q[0], req_q[1], req_q[2]}, 24'h076d01);
		check({20'h0, mark_q[0], mark_q[8]}, 24'h9);
		$display("write done");
	endtask : t_write
	task automatic t_discard();
		logic [15:0] c;
		req_q = {};
		send('{8'ha5, 8'h03, 8'h02, 8'h02, 8'ha8, 8'h05}, 8'h00, c);
		check({12'(req_q.size()), 12'(done_cnt)}, 24'h2);
		node_addr = 8'h03;
		send('{8'had, 8'h03, 8'h02, 8'h02, 8'ha8, 8'h05}, 8'h01, c);
		check({err_seen, value_format_select, 22'(done_cnt)}, 24'hc00003);
		$display("discard done");
	endtask : t_discard
	task automatic t_timeout();
		int n;
		logic [15:0] c;
		multidrop = 1'b0;
		u_bot_host.put(8'ha4);
		u_bot_host.idle();
		for (n = 0; n < 400 && !frame_timeout; n++) @(negedge sys_clk);
		check(24'(n >= 197 && n <= 202), 24'h1);
		send('{8'ha4, 8'h01, 8'h02, 8'ha8}, 8'h00, c);
		check({len_seen, err_seen, 22'(done_cnt)}, 24'h800004);
		$display("timeout done");
	endtask : t_timeout
	task automatic t_answers();
		answer(BOT_ANS_ACK, '{8'h06, 8'h01, 8'h00, 8'h00});
		ans_err = 16'h0609;
		answer(BOT_ANS_NAK, '{8'h07, 8'h01, 8'h06, 8'h09});
		u_bot_host.slow = 1'b1;
		ans_len = 8'h05;
		val_q = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfe, 8'h2d};
		answer(BOT_ANS_RSP, '{8'h05, 8'h05, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfe, 8'h2d});
	endtask : t_answers
	task automatic complete_run();
		error_cnt += u_bot_host.bad;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		t_text();
		t_read();
		t_write();
		t_discard();
		t_timeout();
		t_answers();
		complete_run();
	end
endmodule : tb_binary_object_telegram_framer
